// file: bench/test_two_wire_master_receiver.sv
// bench for the master receiver: receive, restart and stop through registers
// assumes the slave model on pulled-up lines and the bound checker
`timescale 1ns/100ps
module test_two_wire_master_receiver;
  import twmr_pkg::*;
  localparam logic [6:0] SLV = 7'h2A;
  logic              ref_clk;
  logic              reset;
  logic [ADDR_W-1:0] avs_address;
  logic              avs_read;
  logic              avs_write;
  logic [BUS_W-1:0]  avs_writedata;
  logic [BUS_W-1:0]  avs_readdata;
  logic              avs_waitrequest;
  logic              scl_out, scl_oe, sda_out, sda_oe, slv_pull;
  logic [7:0]        q;
  int                errors;
  int                cmp_count;
  wire logic         scl = scl_oe ? scl_out : 1'b1;
  wire logic         sda = (sda_oe ? sda_out : 1'b1) & ~slv_pull;

  twmr_master_receiver uut (
    .ref_clk(ref_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe)
  );
  twmr_slave_model u_slave (.scl(scl), .sda(sda), .sda_pull(slv_pull));

  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // bus and check tasks
  // ----------------------------------------------------------------
  task automatic bus(input logic wr_en, input logic [3:0] a, input logic [7:0] d);
    int n;
    @(posedge ref_clk);
    avs_address   <= a;
    avs_writedata <= {24'h0, d};
    avs_write     <= wr_en;
    avs_read      <= ~wr_en;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) errors++;
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk(q, exp);
  endtask : rd

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr

  // read until the masked field matches, bounded
  task automatic poll(input logic [3:0] a, input logic [7:0] m, input logic [7:0] v);
    int n;
    n = 0;
    do
    begin
      bus(1'b0, a, 8'h00);
      n++;
    end
    while ((q & m) !== v && n < 500);
    if ((q & m) !== v)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, q & m, v);
    end
  endtask : poll

  // write control, wait for the flag, check stretch and state code
  task automatic step(input logic [7:0] c, input logic [7:0] code);
    wr(OFS_CONTROL, c);
    poll(OFS_CONTROL, 8'h80, 8'h80);
    repeat (20) @(posedge ref_clk);
    chk({7'h0, scl_oe}, 8'h01);
    bus(1'b0, OFS_STATE_CODE, 8'h00);
    chk(q & 8'hF8, code);
  endtask : step

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    reset         = 1'b1;
    avs_address   = 4'h0;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h0;
    errors        = 0;
    cmp_count     = 0;
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    rd(OFS_CONTROL, CTRL_RESET);
    rd(OFS_STATE_CODE, ST_IDLE);
    rd(OFS_BYTE_BUFFER, BUFFER_RESET);
    rd(OFS_BIT_RATE, RATE_RESET);
    rd(4'h2, 8'h00);
    $display("test registers done");
    // quarter of two cycles gives a 160 ns serial clock
    wr(OFS_BIT_RATE, 8'h01);
    step(8'hA4, ST_START);
    wr(OFS_CONTROL, 8'h04);
    rd(OFS_CONTROL, 8'h84);
    wr(OFS_BYTE_BUFFER, {SLV, 1'b1});
    step(8'hC4, ST_R_ACK);
    step(8'hC4, ST_RX_ACK);
    rd(OFS_BYTE_BUFFER, 8'hA5);
    step(8'h84, ST_RX_NACK);
    rd(OFS_BYTE_BUFFER, 8'hA6);
    $display("test receive done");
    step(8'hA4, ST_RESTART);
    wr(OFS_BYTE_BUFFER, {~SLV, 1'b1});
    step(8'h84, ST_R_NACK);
    $display("test restart done");
    wr(OFS_CONTROL, 8'h94);
    poll(OFS_STATE_CODE, 8'hF8, ST_IDLE);
    rd(OFS_STATE_CODE, ST_IDLE);
    rd(OFS_CONTROL, 8'h04);
    wr(OFS_BYTE_BUFFER, 8'h55);
    rd(OFS_CONTROL, 8'h0C);
    $display("test stop done");
    close_out();
  end

  initial
  begin
    #2000000;
    errors++;
    close_out();
  end
endmodule : test_two_wire_master_receiver

// file: bench/twmr_master_receiver_assertions.sv
// two-wire master receiver: port assertions and their bind
// assumes an avalon-mm master and open-drain lines with pull-ups
`timescale 1ns/100ps
module twmr_mr_checker
  import twmr_pkg::*;
(
  // clock and reset
  input wire logic              ref_clk,
  input wire logic              reset,
  // avalon-mm
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [BUS_W-1:0]  avs_writedata,
  input wire logic [BUS_W-1:0]  avs_readdata,
  input wire logic              avs_waitrequest,
  // pins
  input wire logic              scl_in,
  input wire logic              scl_out,
  input wire logic              scl_oe,
  input wire logic              sda_in,
  input wire logic              sda_out,
  input wire logic              sda_oe
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  property p_wait_ans;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_ans: assert property (p_wait_ans) else $error("request not answered");
  property p_wait_pulse;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest low too long");
  property p_rd_upper;
    avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0;
  endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
  property p_unmapped;
    avs_read && !avs_waitrequest && avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rd_hold;
    !(avs_read && !avs_waitrequest) |-> $stable(avs_readdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_open_drain;
    scl_out == 1'b0 && sda_out == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("pin driven high");
  property p_start;
    $rose(sda_oe) && !scl_oe |-> scl_in ##1 sda_oe;
  endproperty
  a_start: assert property (p_start) else $error("bad start condition");
  property p_stop;
    $fell(sda_oe) && !scl_oe |-> scl_in ##1 !sda_oe;
  endproperty
  a_stop: assert property (p_stop) else $error("bad stop condition");
endmodule : twmr_mr_checker

bind twmr_master_receiver twmr_mr_checker u_chk (
  .ref_clk(ref_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe)
);

// file: bench/twmr_slave_model.sv
// slave transmitter model: acks its read address, sends counting bytes
// assumes open-drain lines with pull-ups; the master makes scl
`timescale 1ns/100ps
module twmr_slave_model
#(
  parameter logic [6:0] SLAVE_ADDR = 7'h2A,
  parameter logic [7:0] FIRST_BYTE = 8'hA5
)
(
  // bus lines
  input  wire logic scl,
  input  wire logic sda,
  // pull on sda
  output logic      sda_pull
);
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic       acked;
  initial
  begin
    sda_pull = 1'b0;
    tx_reg   = FIRST_BYTE;
    forever
    begin
      @(negedge sda iff scl === 1'b1);
      repeat (8)
      begin
        @(posedge scl);
        shift_reg = {shift_reg[6:0], sda};
      end
      @(negedge scl);
      acked    = (shift_reg == {SLAVE_ADDR, 1'b1});
      sda_pull = acked;
      @(negedge scl);
      while (acked)
      begin
        for (int i = 7; i >= 0; i--)
        begin
          sda_pull = ~tx_reg[i];
          @(negedge scl);
        end
        // let the master answer; a nack ends the burst
        sda_pull = 1'b0;
        @(posedge scl);
        acked  = ~sda;
        tx_reg = tx_reg + 8'h01;
        @(negedge scl);
      end
    end
  end
endmodule : twmr_slave_model

// file: hw/twmr_line_sync.sv
// two-wire line sampler: synchronises scl and sda and tracks bus occupancy
// assumes both pins are asynchronous to ref_clk and idle high
`timescale 1ns/100ps
module twmr_line_sync
  import twmr_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // pins
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  // synchronised view
  output twmr_line_t       line
);

  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] sync;
    logic [1:0] prev;
    logic       busy;
  } twmr_sync_st_t;

  twmr_sync_st_t s_reg;
  twmr_sync_st_t s_next;

  // ----------------------------------------------------------------
  // start and stop detection comparing the second stage with the third
  // ----------------------------------------------------------------
  always_comb
  begin
    s_next      = s_reg;
    s_next.meta = {scl_in, sda_in};
    s_next.sync = s_reg.meta;
    s_next.prev = s_reg.sync;
    if (s_reg.sync[1] && s_reg.prev[1] && s_reg.prev[0] && !s_reg.sync[0])
      s_next.busy = 1'b1;
    else if (s_reg.sync[1] && s_reg.prev[1] && !s_reg.prev[0] && s_reg.sync[0])
      s_next.busy = 1'b0;
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      s_reg <= '{meta: 2'h3, sync: 2'h3, prev: 2'h3, busy: 1'b0};
    else
      s_reg <= s_next;
  end

  assign line = '{scl: s_reg.sync[1], sda: s_reg.sync[0], busy: s_reg.busy};

endmodule : twmr_line_sync

// file: hw/twmr_master_receiver.sv
// two-wire master receiver with avalon-mm register access
// assumes an avalon-mm master on ref_clk and open-drain pins with pull-ups
//
// Function
// - master mode is entered only after a START has been issued
// - direction bit of the address after START selects receive or transmit
// - start request with flag clear and enable set waits for a free bus
// - writing one to the flag clears it, zero leaves it alone
// - after a transmitted START the flag sets with code 0x08
// - after the read address the flag sets with 0x38, 0x40 or 0x48
// - each received byte sits in the byte buffer when the flag sets
// - stop request with the flag cleared generates STOP
// - start request with the flag cleared generates a repeated START
// - repeated START reports 0x10; next address picks the mode
// - on 0x38 the bus is released, or START waits for a free bus
// - on 0x40 next byte is received, acked per acknowledge enable
// - on 0x48 requests give repeated START, STOP or STOP then START
// - on 0x50 another byte is received, acked per acknowledge enable
// - on 0x58 requests give repeated START, STOP or STOP then START
// - hardware clears the stop request once STOP has gone out
//
// Our own choices: the Avalon-MM register port and the address map.
`timescale 1ns/100ps
module twmr_master_receiver
  import twmr_pkg::*;
#(
  parameter int unsigned DIV_W = 14
)
(
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              reset,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [BUS_W-1:0]  avs_writedata,
  output logic      [BUS_W-1:0]  avs_readdata,
  output logic                   avs_waitrequest,
  // two-wire pins, open drain
  input  wire logic              scl_in,
  output logic                   scl_out,
  output logic                   scl_oe,
  input  wire logic              sda_in,
  output logic                   sda_out,
  output logic                   sda_oe
);

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  generate
    if (DIV_W < BYTE_W + 2 * PRE_W + 2)
      $error("DIV_W too small for the largest quarter-bit count");
  endgenerate

  typedef struct packed {
    twmr_ctrl_t        ctrl;
    logic [7:0]        code;
    logic [PRE_W-1:0]  pre;
    logic [7:0]        buffer;
    logic [7:0]        rate;
    twmr_eng_t         eng;
    twmr_job_t         job;
    logic [7:0]        shift;
    logic [3:0]        bitn;
    logic              ack_drive;
    logic              rs;
    logic              master;
    logic              dir_read;
    logic [DIV_W-1:0]  cnt;
    logic              scl_oe;
    logic              sda_oe;
    logic              wait_r;
    logic [BUS_W-1:0]  rdata;
  } twmr_st_t;

  twmr_st_t    s_reg;
  twmr_st_t    s_next;
  twmr_line_t  line;
  twmr_ctrl_t  wr_ctrl;
  logic        tick;
  logic        hw_set;
  logic        wr_ok;
  logic        arb_bit;
  logic        ack_seen;
  logic [DIV_W-1:0] quarter;

  // ----------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    reg_hit = (a == ofs);
  endfunction : reg_hit

  function automatic logic [BUS_W-1:0] read_word(input twmr_st_t st, input logic [ADDR_W-1:0] a);
    read_word = '0;
    if (reg_hit(a, OFS_CONTROL))
      read_word = BUS_W'(st.ctrl);
    else if (reg_hit(a, OFS_STATE_CODE))
      read_word = BUS_W'(st.code | BYTE_W'(st.pre));
    else if (reg_hit(a, OFS_BYTE_BUFFER))
      read_word = BUS_W'(st.buffer);
    else if (reg_hit(a, OFS_BIT_RATE))
      read_word = BUS_W'(st.rate);
  endfunction : read_word

  // ----------------------------------------------------------------
  // pin sampling
  // ----------------------------------------------------------------
  twmr_line_sync u_line_sync (
    .ref_clk (ref_clk),
    .reset   (reset),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .line    (line)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_next   = s_reg;
    hw_set   = 1'b0;
    tick     = (s_reg.cnt == '0);
    quarter  = DIV_W'(s_reg.rate) << {s_reg.pre, 1'b0};
    wr_ok    = avs_write && !s_reg.wait_r;
    wr_ctrl  = twmr_ctrl_t'(avs_writedata[BYTE_W-1:0]);
    arb_bit  = (s_reg.bitn == ACK_BIT) ? (s_reg.job == JOB_RX) : (s_reg.job != JOB_RX);
    ack_seen = !line.sda;

    // bus slave: one wait cycle, then the request is taken
    s_next.wait_r = 1'b1;
    if ((avs_read || avs_write) && s_reg.wait_r)
    begin
      s_next.wait_r = 1'b0;
      // read data only moves on a read, so it stands until the next read answer
      if (avs_read)
        s_next.rdata = read_word(s_reg, avs_address);
    end

    if (wr_ok && reg_hit(avs_address, OFS_CONTROL))
    begin
      if (wr_ctrl.step_done_flag)
        s_next.ctrl.step_done_flag = 1'b0;
      s_next.ctrl.ack_enable       = wr_ctrl.ack_enable;
      s_next.ctrl.start_request    = wr_ctrl.start_request;
      s_next.ctrl.stop_request     = wr_ctrl.stop_request;
      s_next.ctrl.interface_enable = wr_ctrl.interface_enable;
      s_next.ctrl.irq_enable       = wr_ctrl.irq_enable;
    end
    if (wr_ok && reg_hit(avs_address, OFS_BYTE_BUFFER))
    begin
      // the buffer may only change while the bus is stalled on the flag
      if (s_reg.ctrl.step_done_flag)
      begin
        s_next.buffer                    = avs_writedata[BYTE_W-1:0];
        s_next.ctrl.write_collision_flag = 1'b0;
      end
      else
        s_next.ctrl.write_collision_flag = 1'b1;
    end
    if (wr_ok && reg_hit(avs_address, OFS_STATE_CODE))
      s_next.pre = avs_writedata[PRE_LSB +: PRE_W];
    if (wr_ok && reg_hit(avs_address, OFS_BIT_RATE))
      s_next.rate = avs_writedata[BYTE_W-1:0];

    // bit engine
    unique case (s_reg.eng)
      ENG_IDLE:
      begin
        s_next.scl_oe = 1'b0;
        s_next.sda_oe = 1'b0;
        if (s_reg.ctrl.interface_enable && s_reg.ctrl.start_request && !s_reg.ctrl.step_done_flag)
        begin
          s_next.eng = ENG_WAIT_FREE;
          s_next.rs  = 1'b0;
        end
      end
      ENG_WAIT_FREE:
        if (!line.busy)
          s_next.eng = ENG_START_A;
      ENG_START_A:
      begin
        s_next.sda_oe = 1'b1;
        if (tick)
          s_next.eng = ENG_START_B;
      end
      ENG_START_B:
      begin
        s_next.scl_oe = 1'b1;
        if (tick)
        begin
          s_next.master = 1'b1;
          s_next.code   = s_reg.rs ? ST_RESTART : ST_START;
          hw_set        = 1'b1;
          s_next.eng    = ENG_HOLD;
        end
      end
      ENG_HOLD:
      begin
        s_next.scl_oe = 1'b1;
        s_next.sda_oe = 1'b0;
        if (!s_reg.ctrl.step_done_flag)
        begin
          if ((s_reg.code == ST_START) || (s_reg.code == ST_RESTART))
          begin
            s_next.job      = JOB_ADDR;
            s_next.shift    = s_reg.buffer;
            s_next.dir_read = s_reg.buffer[0];
            s_next.bitn     = '0;
            s_next.eng      = ENG_BIT_LOW;
          end
          else if (s_reg.ctrl.stop_request)
            s_next.eng = ENG_STOP_A;
          else if (s_reg.ctrl.start_request)
            s_next.eng = ENG_RS_A;
          else if (s_reg.dir_read && ((s_reg.code == ST_R_ACK) || (s_reg.code == ST_RX_ACK)))
          begin
            s_next.job       = JOB_RX;
            s_next.ack_drive = s_reg.ctrl.ack_enable;
            s_next.bitn      = '0;
            s_next.eng       = ENG_BIT_LOW;
          end
          else if (!s_reg.dir_read)
          begin
            s_next.job   = JOB_TX;
            s_next.shift = s_reg.buffer;
            s_next.bitn  = '0;
            s_next.eng   = ENG_BIT_LOW;
          end
        end
      end
      ENG_BIT_LOW:
      begin
        s_next.scl_oe = 1'b1;
        if (s_reg.bitn == ACK_BIT)
          s_next.sda_oe = (s_reg.job == JOB_RX) && s_reg.ack_drive;
        else
          s_next.sda_oe = (s_reg.job != JOB_RX) && !s_reg.shift[BYTE_W-1];
        if (tick)
          s_next.eng = ENG_BIT_RISE;
      end
      ENG_BIT_RISE:
      begin
        // the slave may stretch the clock: wait until the line is seen high
        s_next.scl_oe = 1'b0;
        if (line.scl)
          s_next.eng = ENG_BIT_HIGH;
      end
      ENG_BIT_HIGH:
        if (tick)
        begin
          if (!s_reg.sda_oe && !line.sda && arb_bit)
          begin
            s_next.eng    = ENG_IDLE;
            s_next.sda_oe = 1'b0;
            s_next.master = 1'b0;
            s_next.code   = ST_ARB_LOST;
            hw_set        = 1'b1;
          end
          else if (s_reg.bitn == ACK_BIT)
          begin
            s_next.scl_oe = 1'b1;
            s_next.eng    = ENG_HOLD;
            hw_set        = 1'b1;
            unique case (s_reg.job)
              JOB_ADDR:
                if (s_reg.dir_read)
                  s_next.code = ack_seen ? ST_R_ACK : ST_R_NACK;
                else
                  s_next.code = ack_seen ? ST_W_ACK : ST_W_NACK;
              JOB_TX:
                s_next.code = ack_seen ? ST_TX_ACK : ST_TX_NACK;
              JOB_RX:
              begin
                s_next.buffer = s_reg.shift;
                s_next.code   = s_reg.ack_drive ? ST_RX_ACK : ST_RX_NACK;
              end
              default:
                s_next.code = ST_IDLE;
            endcase
          end
          else
          begin
            s_next.shift  = {s_reg.shift[BYTE_W-2:0], line.sda};
            s_next.bitn   = s_reg.bitn + 4'h1;
            s_next.scl_oe = 1'b1;
            s_next.eng    = ENG_BIT_LOW;
          end
        end
      ENG_RS_A:
      begin
        s_next.scl_oe = 1'b1;
        s_next.sda_oe = 1'b0;
        if (tick)
          s_next.eng = ENG_RS_B;
      end
      ENG_RS_B:
      begin
        s_next.scl_oe = 1'b0;
        if (line.scl && tick)
        begin
          s_next.rs  = 1'b1;
          s_next.eng = ENG_START_A;
        end
      end
      ENG_STOP_A:
      begin
        s_next.scl_oe = 1'b1;
        s_next.sda_oe = 1'b1;
        if (tick)
          s_next.eng = ENG_STOP_B;
      end
      ENG_STOP_B:
      begin
        s_next.scl_oe = 1'b0;
        if (line.scl && tick)
          s_next.eng = ENG_STOP_C;
      end
      ENG_STOP_C:
      begin
        s_next.sda_oe = 1'b0;
        if (tick)
        begin
          s_next.master            = 1'b0;
          s_next.ctrl.stop_request = 1'b0;
          s_next.code              = ST_IDLE;
          s_next.rs                = 1'b0;
          s_next.eng = s_reg.ctrl.start_request ? ENG_WAIT_FREE : ENG_IDLE;
        end
      end
      default:
        s_next.eng = ENG_IDLE;
    endcase

    // quarter-bit enable: restarts on every phase change
    if (tick || (s_next.eng != s_reg.eng))
      s_next.cnt = quarter;
    else
      s_next.cnt = s_reg.cnt - DIV_W'(1);

    // hardware set wins over a clear in the same cycle
    if (hw_set)
      s_next.ctrl.step_done_flag = 1'b1;

    if (!s_reg.ctrl.interface_enable)
    begin
      s_next.eng    = ENG_IDLE;
      s_next.scl_oe = 1'b0;
      s_next.sda_oe = 1'b0;
      s_next.master = 1'b0;
      s_next.code   = ST_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      s_reg           <= '0;
      s_reg.ctrl      <= twmr_ctrl_t'(CTRL_RESET);
      s_reg.code      <= ST_IDLE;
      s_reg.pre       <= PRE_RESET;
      s_reg.buffer    <= BUFFER_RESET;
      s_reg.rate      <= RATE_RESET;
      s_reg.eng       <= ENG_IDLE;
      s_reg.job       <= JOB_ADDR;
      s_reg.wait_r    <= 1'b1;
    end
    else
      s_reg <= s_next;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign avs_readdata    = s_reg.rdata;
  assign avs_waitrequest = s_reg.wait_r;
  assign scl_oe          = s_reg.scl_oe;
  assign sda_oe          = s_reg.sda_oe;
  assign scl_out         = s_reg.rs & 1'b0;
  assign sda_out         = s_reg.rs & 1'b0;

endmodule : twmr_master_receiver

// file: hw/twmr_pkg.sv
// two-wire master receiver: shared constants, register map and types
// assumes a 50 MHz ref_clk and an avalon-mm master on the register side
package twmr_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 20;
  localparam int QUARTER_TIME_NS = 2500;
  localparam int QUARTER_CYCLES  = (QUARTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // register map (byte addresses) and field layout
  // ----------------------------------------------------------------
  localparam int         ADDR_W          = 4;
  localparam int         BYTE_W          = 8;
  localparam int         BUS_W           = 32;
  localparam int         PRE_LSB         = 0;
  localparam int         PRE_W           = 2;
  localparam logic [3:0] OFS_CONTROL     = 4'h0;
  localparam logic [3:0] OFS_STATE_CODE  = 4'h4;
  localparam logic [3:0] OFS_BYTE_BUFFER = 4'h8;
  localparam logic [3:0] OFS_BIT_RATE    = 4'hC;
  localparam logic [7:0] CTRL_RESET      = 8'h00;
  localparam logic [7:0] BUFFER_RESET    = 8'hFF;
  localparam logic [7:0] RATE_RESET      = 8'(QUARTER_CYCLES - 1);
  localparam logic [1:0] PRE_RESET       = 2'h0;

  // ----------------------------------------------------------------
  // status codes
  // ----------------------------------------------------------------
  localparam logic [7:0] ST_START    = 8'h08;
  localparam logic [7:0] ST_RESTART  = 8'h10;
  localparam logic [7:0] ST_W_ACK    = 8'h18;
  localparam logic [7:0] ST_W_NACK   = 8'h20;
  localparam logic [7:0] ST_TX_ACK   = 8'h28;
  localparam logic [7:0] ST_TX_NACK  = 8'h30;
  localparam logic [7:0] ST_ARB_LOST = 8'h38;
  localparam logic [7:0] ST_R_ACK    = 8'h40;
  localparam logic [7:0] ST_R_NACK   = 8'h48;
  localparam logic [7:0] ST_RX_ACK   = 8'h50;
  localparam logic [7:0] ST_RX_NACK  = 8'h58;
  localparam logic [7:0] ST_IDLE     = 8'hF8;

  localparam logic [3:0] ACK_BIT     = 4'h8;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic step_done_flag;
    logic ack_enable;
    logic start_request;
    logic stop_request;
    logic write_collision_flag;
    logic interface_enable;
    logic reserved;
    logic irq_enable;
  } twmr_ctrl_t;

  typedef struct packed {
    logic scl;
    logic sda;
    logic busy;
  } twmr_line_t;

  typedef enum logic [3:0] {
    ENG_IDLE, ENG_WAIT_FREE, ENG_START_A, ENG_START_B, ENG_HOLD,
    ENG_BIT_LOW, ENG_BIT_RISE, ENG_BIT_HIGH, ENG_RS_A, ENG_RS_B,
    ENG_STOP_A, ENG_STOP_B, ENG_STOP_C
  } twmr_eng_t;

  typedef enum logic [1:0] {
    JOB_ADDR, JOB_TX, JOB_RX
  } twmr_job_t;

endpackage : twmr_pkg
